// [src/switch_input_config_regs.sv]
`include "switch_input_config_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module switch_input_config_regs
  import switch_input_config_pkg::*;
#(
  parameter int NUM_CH = `CFG_NUM_CH
) (
  // Clock, reset and enable
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  input  wire logic                      ce,
  // Register port from the serial interface core
  input  wire logic [`CFG_ADDR_W-1:0]    reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic [`CFG_DATA_W-1:0]    reg_wdata,
  input  wire logic                      reg_rd,
  output logic      [`CFG_DATA_W-1:0]    reg_rdata,
  // Polling walk control
  input  wire logic                      run,
  input  wire logic                      sample_done,
  output logic                           poll_active,
  output logic      [4:0]                poll_channel,
  output logic                           poll_sink,
  output logic      [`CFG_LEVEL_W-1:0]   poll_level,
  // Static configuration towards the current sources
  output logic      [NUM_CH-1:0]         channel_enable,
  output logic      [`CFG_NUM_DIR_CH-1:0] channel_direction,
  output logic      [3*`CFG_NUM_WET_CH-1:0] wetting_level
);

  logic [`CFG_DATA_W-1:0]     input_channel_enables;
  logic [`CFG_NUM_DIR_CH-1:0] current_direction_select;
  logic [`CFG_DATA_W-1:0]     wetting_level_low_inputs;
  poll_state_t                state;
  poll_state_t                next_state;
  logic [4:0]                 chan;
  logic [4:0]                 next_chan;

  // Raw level code to current step
  function automatic wetting_level_t decode_level(input logic [2:0] code);
    wetting_level_t lvl;
    lvl = WET_15MA;
    unique case (code)
      3'h0: lvl = WET_OFF;
      3'h1: lvl = WET_1MA;
      3'h2: lvl = WET_2MA;
      3'h3: lvl = WET_5MA;
      3'h4: lvl = WET_10MA;
      3'h5, 3'h6, 3'h7: lvl = WET_15MA;
    endcase
    return lvl;
  endfunction : decode_level

  // Field position of an input within the wetting register
  function automatic logic [4:0] field_lsb(input logic [4:0] ch);
    logic [4:0] lsb;
    lsb = `CFG_LSB_PAIR_0_1;
    unique case (ch)
      5'h00, 5'h01: lsb = `CFG_LSB_PAIR_0_1;
      5'h02, 5'h03: lsb = `CFG_LSB_PAIR_2_3;
      5'h04:        lsb = `CFG_LSB_CH4;
      5'h05:        lsb = `CFG_LSB_CH5;
      5'h06, 5'h07: lsb = `CFG_LSB_PAIR_6_7;
      5'h08, 5'h09: lsb = `CFG_LSB_PAIR_8_9;
      5'h0A:        lsb = `CFG_LSB_CH10;
      5'h0B:        lsb = `CFG_LSB_CH11;
      default:      lsb = `CFG_LSB_PAIR_0_1;
    endcase
    return lsb;
  endfunction : field_lsb

  // Address decode
  wire hit_enables   = reg_addr == `CFG_OFS_ENABLES;
  wire hit_direction = reg_addr == `CFG_OFS_DIRECTION;
  wire hit_wetting   = reg_addr == `CFG_OFS_WETTING;
  wire wr_en         = ce && reg_wr;

  // Reserved direction bits have no storage, so they always read zero
  wire [`CFG_DATA_W-1:0] direction_view =
    {{(`CFG_DATA_W-`CFG_NUM_DIR_CH){1'b0}},
     current_direction_select};

  wire [`CFG_DATA_W-1:0] read_mux =
    hit_enables   ? input_channel_enables :
    hit_direction ? direction_view :
    hit_wetting   ? wetting_level_low_inputs :
                    {`CFG_DATA_W{1'b0}};

  // Writes are taken even while the walk runs; stopping it first is
  // left to the host so that a reconfiguration can be staged freely.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      input_channel_enables    <= `CFG_RST_ENABLES;
      current_direction_select <= `CFG_RST_DIRECTION;
      wetting_level_low_inputs <= `CFG_RST_WETTING;
    end else if (wr_en) begin
      if (hit_enables)
        input_channel_enables <= reg_wdata;
      if (hit_direction)
        current_direction_select <=
          reg_wdata[`CFG_NUM_DIR_CH-1:0];
      if (hit_wetting)
        wetting_level_low_inputs <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn)
      reg_rdata <= {`CFG_DATA_W{1'b0}};
    else if (ce && reg_rd)
      reg_rdata <= read_mux;
  end

  // Per-input wetting level, registered for clean outputs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wetting_level <= {(3*`CFG_NUM_WET_CH){1'b0}};
    end else if (ce) begin
      for (int i = 0; i < `CFG_NUM_WET_CH; i++) begin
        wetting_level[3*i +: 3] <= decode_level(
          wetting_level_low_inputs[field_lsb(5'(i)) +: 3]);
      end
    end
  end

  assign channel_enable    = input_channel_enables[NUM_CH-1:0];
  assign channel_direction = current_direction_select;

  // Polling walk
  wire       any_enabled = |input_channel_enables[NUM_CH-1:0];
  wire       chan_on     = input_channel_enables[chan];
  wire [4:0] chan_inc    = (chan == 5'(NUM_CH-1)) ? 5'h00 : chan + 5'h01;

  always_comb begin
    next_state = state;
    next_chan  = chan;
    unique case (state)
      POLL_IDLE:
        if (run && any_enabled)
          next_state = POLL_SEARCH;
      POLL_SEARCH:
        if (!run || !any_enabled)
          next_state = POLL_IDLE;
        else if (chan_on)
          next_state = POLL_SAMPLE;
        else
          next_chan = chan_inc;
      POLL_SAMPLE:
        if (!run) begin
          next_state = POLL_IDLE;
        end else if (sample_done) begin
          next_state = POLL_SEARCH;
          next_chan  = chan_inc;
        end
      default:
        next_state = POLL_IDLE;
    endcase
  end

  // Sink and level for the channel under test, latched on entry
  wire       cur_sink  = (chan < 5'(`CFG_NUM_DIR_CH)) ?
                         current_direction_select[chan[3:0]] : 1'b0;
  // Inputs above 11 are set elsewhere, so they report no current here
  wire [2:0] cur_level = (chan < 5'(`CFG_NUM_WET_CH)) ?
    decode_level(wetting_level_low_inputs[field_lsb(chan) +: 3]) :
    WET_OFF;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state      <= POLL_IDLE;
      chan       <= 5'h00;
      poll_sink  <= 1'b0;
      poll_level <= 3'h0;
    end else if (ce) begin
      state <= next_state;
      chan  <= next_chan;
      if (state == POLL_SEARCH && next_state == POLL_SAMPLE) begin
        poll_sink  <= cur_sink;
        poll_level <= cur_level;
      end
    end
  end

  assign poll_active  = state == POLL_SAMPLE;
  assign poll_channel = chan;

  chk_skip_disabled:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && state == POLL_SEARCH && run && !chan_on && any_enabled
    |=> !poll_active)
    else $error("Sampling started on a disabled channel");

  chk_sample_enabled:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(poll_active) |-> $past(input_channel_enables[chan]))
    else $error("Walk stopped on a channel that was disabled");

  chk_enable_write:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && hit_enables |=> channel_enable == $past(reg_wdata))
    else $error("Enable write did not reach the channels");

  chk_reset_values:
  assert property (@(posedge sys_clk)
    !$past(resetn) |-> channel_enable == 24'h000000 &&
      channel_direction == 10'h000 &&
      wetting_level_low_inputs == 24'h000000)
    else $error("Configuration not zero after reset");

  chk_dir_sink:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(poll_active) && $past(chan) < 5'h0A |->
      poll_sink == $past(current_direction_select[chan[3:0]]))
    else $error("Sink choice does not match direction bit");

  chk_dir_reserved:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && reg_rd && hit_direction |=> reg_rdata[23:10] == 14'h0000)
    else $error("Reserved direction bits read non-zero");

  chk_reserved_drop:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && hit_direction ##1 ce && reg_rd && hit_direction
    |=> reg_rdata == {14'h0000, $past(reg_wdata[9:0], 2)})
    else $error("Reserved direction write was not dropped");

  chk_level_top:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && wetting_level_low_inputs[8:6] >= 3'h5 |=>
      wetting_level[14:12] == 3'h5)
    else $error("Codes 5 to 7 must give the top current");

  chk_pair_share:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[2:0] == wetting_level[5:3] &&
      wetting_level[20:18] == wetting_level[23:21] &&
      wetting_level[26:24] == wetting_level[29:27] &&
      wetting_level[5:3] == decode_level($past(
        wetting_level_low_inputs[2:0])))
    else $error("Paired inputs disagree on wetting level");

  chk_single_field:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[35:33] ==
      decode_level($past(wetting_level_low_inputs[23:21])))
    else $error("Input 11 level does not follow its field");

  chk_wet_write:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && hit_wetting ##1 ce && reg_rd && hit_wetting
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Wetting register readback mismatch");

  chk_dir_write:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_en && hit_direction |=>
      channel_direction == $past(reg_wdata[9:0]))
    else $error("Direction write did not reach the sources");

  chk_source_high:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(poll_active) && $past(chan) >= 5'h0A |-> !poll_sink)
    else $error("Inputs above 9 must report current sourcing");

  chk_level_plain:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && wetting_level_low_inputs[11:9] <= 3'h4 |=>
      wetting_level[17:15] == $past(wetting_level_low_inputs[11:9]))
    else $error("Codes 0 to 4 must keep their own current step");

  chk_pair_2_3:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[8:6] == wetting_level[11:9] &&
      wetting_level[8:6] == decode_level($past(
        wetting_level_low_inputs[5:3])))
    else $error("Inputs 2 and 3 do not follow their shared field");

  chk_pair_6_7:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[20:18] ==
      decode_level($past(wetting_level_low_inputs[14:12])))
    else $error("Inputs 6 and 7 do not follow their shared field");

  chk_pair_8_9:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[26:24] ==
      decode_level($past(wetting_level_low_inputs[17:15])))
    else $error("Inputs 8 and 9 do not follow their shared field");

  chk_single_rest:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce |=> wetting_level[14:12] ==
        decode_level($past(wetting_level_low_inputs[8:6])) &&
      wetting_level[17:15] ==
        decode_level($past(wetting_level_low_inputs[11:9])) &&
      wetting_level[32:30] ==
        decode_level($past(wetting_level_low_inputs[20:18])))
    else $error("Single-input level does not follow its field");

  // A sample already running is ended by run or sample_done, not here
  chk_none_enabled:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    ce && !any_enabled && state != POLL_SAMPLE |=> !poll_active)
    else $error("Walk sampled although every channel is disabled");

  chk_freeze_hold:
  assert property (@(posedge sys_clk) disable iff (!resetn)
    !ce |=> $stable(channel_enable) && $stable(channel_direction) &&
      $stable(wetting_level))
    else $error("Configuration moved while the clock enable was low");

endmodule : switch_input_config_regs

`default_nettype wire

// [src/switch_input_config_consts.svh]
// Operation
// - Disabled channels are skipped by the polling walk
// - Enable bit n turns on input channel n
// - Enable register at 1Bh, resets to zero
// - Direction bit: 0 sources current, 1 sinks
// - Direction bits 23 to 10 read zero
// - Direction register at 1Ch, resets to zero
// - Level codes: 0,1,2,5,10 mA; 5-7 give 15
// - Pair fields shared by inputs 0/1,2/3,6/7,8/9
// - Wetting register at 1Dh, resets to zero
`ifndef SWITCH_INPUT_CONFIG_CONSTS_SVH
`define SWITCH_INPUT_CONFIG_CONSTS_SVH

`define CFG_ADDR_W         6
`define CFG_DATA_W         24
`define CFG_NUM_CH         24
`define CFG_NUM_DIR_CH     10
`define CFG_NUM_WET_CH     12
`define CFG_LEVEL_W        3

`define CFG_OFS_ENABLES    6'h1B
`define CFG_OFS_DIRECTION  6'h1C
`define CFG_OFS_WETTING    6'h1D

`define CFG_RST_ENABLES    24'h000000
`define CFG_RST_DIRECTION  10'h000
`define CFG_RST_WETTING    24'h000000

`define CFG_LSB_PAIR_0_1   5'h00
`define CFG_LSB_PAIR_2_3   5'h03
`define CFG_LSB_CH4        5'h06
`define CFG_LSB_CH5        5'h09
`define CFG_LSB_PAIR_6_7   5'h0C
`define CFG_LSB_PAIR_8_9   5'h0F
`define CFG_LSB_CH10       5'h12
`define CFG_LSB_CH11       5'h15

`endif

// [src/switch_input_config_pkg.sv]
package switch_input_config_pkg;

  typedef enum logic [2:0] {
    WET_OFF  = 3'h0,
    WET_1MA  = 3'h1,
    WET_2MA  = 3'h2,
    WET_5MA  = 3'h3,
    WET_10MA = 3'h4,
    WET_15MA = 3'h5
  } wetting_level_t;

  typedef enum logic [1:0] {
    POLL_IDLE   = 2'h0,
    POLL_SEARCH = 2'h1,
    POLL_SAMPLE = 2'h3
  } poll_state_t;

endpackage : switch_input_config_pkg

// [testbench/switch_contact_model.sv]
`timescale 1ns/100ps
`default_nettype none

module switch_contact_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Sampling handshake
  input  wire logic poll_active,
  input  wire logic slow,
  output logic      sample_done
);
  int cnt;

  // Contacts settle after a short or a long wetting time
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt         <= 0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= 1'b0;
      if (!poll_active || sample_done) begin
        cnt <= 0;
      end else if (cnt == (slow ? 5 : 0)) begin
        sample_done <= 1'b1;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : switch_contact_model

`default_nettype wire

// [testbench/switch_input_config_regs_tb_top.sv]
`include "switch_input_config_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module switch_input_config_regs_tb_top;
  // Reset starts high so that its first assertion is a real falling edge
  logic sys_clk = 0, resetn = 1, ce = 1, reg_wr = 0, reg_rd = 0;
  logic run = 0, slow = 0, sample_done, poll_active, poll_sink;
  logic [5:0] reg_addr = 0;
  logic [23:0] reg_wdata = 0, reg_rdata, channel_enable, v, w;
  logic [4:0] poll_channel;
  logic [2:0] poll_level;
  logic [9:0] channel_direction;
  logic [35:0] wetting_level, x;
  logic [23:0] exp_q[$];
  logic [8:0] wq[$];
  logic was_rd = 0, act_d = 0;
  int n_fail = 0, checks = 0, cyc = 0;

  switch_input_config_regs dut (.sys_clk(sys_clk), .resetn(resetn),
    .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run(run),
    .sample_done(sample_done), .poll_active(poll_active),
    .poll_channel(poll_channel), .poll_sink(poll_sink),
    .poll_level(poll_level), .channel_enable(channel_enable),
    .channel_direction(channel_direction), .wetting_level(wetting_level));

  switch_contact_model far (.sys_clk(sys_clk), .resetn(resetn),
    .poll_active(poll_active), .slow(slow), .sample_done(sample_done));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [35:0] s, input logic [35:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic acc(input logic wr, input logic [5:0] a,
                     input logic [23:0] d);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wr = wr;
    reg_rd = !wr;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 0; reg_rd = 0;
  endtask : acc

  task automatic rd(input logic [5:0] a, input logic [23:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 24'h0);
  endtask : rd

  // Write, then read in the very next cycle
  task automatic wr_rd(input logic [5:0] a, input logic [23:0] d,
                       input logic [23:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    #1;
    reg_addr = a;
    reg_wr = 1;
    reg_rd = 0;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 0;
    reg_rd = 1;
    @(posedge sys_clk);
    #1;
    reg_rd = 0;
  endtask : wr_rd

  function automatic logic [2:0] lvl(logic [23:0] wc, int ch);
    int f[12] = '{0, 0, 1, 1, 2, 3, 4, 4, 5, 5, 6, 7};
    logic [2:0] c = wc[3*f[ch] +: 3];
    return c > 4 ? 3'h5 : c;
  endfunction : lvl

  // Reset clears the walk, so each run starts its search at channel 0
  task automatic walk(input logic s);
    logic [23:0] en, dr, wc;
    int c, e;
    en = $urandom | 24'h1;
    dr = $urandom;
    wc = $urandom;
    @(posedge sys_clk);
    #1 resetn = 0;
    repeat (6) @(posedge sys_clk);
    #1 resetn = 1;
    rd(`CFG_OFS_ENABLES, 0);
    rd(`CFG_OFS_DIRECTION, 0);
    rd(`CFG_OFS_WETTING, 0);
    // Configuration only while stopped
    acc(1, `CFG_OFS_ENABLES, en);
    acc(1, `CFG_OFS_DIRECTION, dr);
    acc(1, `CFG_OFS_WETTING, wc);
    check(channel_enable, en);
    check(channel_direction, dr[9:0]);
    c = 0;
    repeat (6) begin
      e = c;
      while (!en[e]) e = (e + 1) % 24;
      wq.push_back({(e < 10) & dr[e], e < 12 ? lvl(wc, e) : 3'h0, 5'(e)});
      c = (e + 1) % 24;
    end
    slow = s; run = 1;
    for (int i = 0; i < 400 && wq.size() > 0; i++) @(posedge sys_clk);
    #1 run = 0;
    repeat (3) @(posedge sys_clk);
    check(poll_active, 0);
    check(wq.size(), 0);
  endtask : walk

  always begin
    @(posedge sys_clk);
    #2;
    if (was_rd && exp_q.size() > 0)
      check(reg_rdata, exp_q.pop_front());
    if (poll_active && !act_d && wq.size() > 0)
      check({poll_sink, poll_level, poll_channel},
            wq.pop_front());
    was_rd = reg_rd & ce;
    act_d = poll_active;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'hEDF8958E));
    walk(0);
    repeat (4) begin
      v = $urandom;
      acc(1, `CFG_OFS_ENABLES, v);
      rd(`CFG_OFS_ENABLES, v);
      acc(1, `CFG_OFS_DIRECTION, v);
      rd(`CFG_OFS_DIRECTION, {14'h0, v[9:0]});
      wr_rd(`CFG_OFS_DIRECTION, ~v, {14'h0, ~v[9:0]});
      ce = 0;
      acc(1, `CFG_OFS_ENABLES, ~v);
      ce = 1;
      rd(`CFG_OFS_ENABLES, v);
      acc(1, 6'h1E, v);
      rd(6'h1E, 0);
    end
    for (int k = 0; k < 2; k++) begin
      w = 0;
      for (int i = 0; i < 8; i++) w[3*i +: 3] = 3'(k ? 7 - i : i);
      wr_rd(`CFG_OFS_WETTING, w, w);
      repeat (2) @(posedge sys_clk);
      #1;
      for (int i = 0; i < 12; i++) x[3*i +: 3] = lvl(w, i);
      check(wetting_level, x);
    end
    walk(1);
    give_verdict();
  end
endmodule : switch_input_config_regs_tb_top

`default_nettype wire
